// [hdl/cbs_pkg.sv]
package cbs_pkg;
    // ****************************************
    // widths
    // ****************************************
    localparam int PC_W = 16;
    localparam int K_W = 7;
    localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
    localparam logic [PC_W-1:0] PC_ONE = 16'h0001;
    localparam logic [PC_W-1:0] PC_TWO = 16'h0002;
    localparam logic [PC_W-1:0] PC_THREE = 16'h0003;
    // status flag positions
    localparam logic [2:0] FLAG_CARRY = 3'h0;
    localparam logic [2:0] FLAG_ZERO = 3'h1;

    // ****************************************
    // operations
    // ****************************************
    typedef enum logic [3:0] {
        CBS_OP_NONE = 4'h0,
        CBS_OP_SKIP_BIT_SET = 4'h1,
        CBS_OP_BRANCH_FLAG_SET = 4'h2,
        CBS_OP_BRANCH_FLAG_CLEAR = 4'h3,
        CBS_OP_BRANCH_ZERO_SET = 4'h4,
        CBS_OP_BRANCH_ZERO_CLEAR = 4'h5,
        CBS_OP_BRANCH_CARRY_SET = 4'h6,
        CBS_OP_BRANCH_CARRY_CLEAR = 4'h7,
        CBS_OP_BRANCH_UNSIGNED_GE = 4'h8
    } cbs_op_t;

    typedef struct packed {
        cbs_op_t op;
        logic [2:0] sel;
        logic [K_W-1:0] offset;
        logic [7:0] io_value;
        logic next_is_long;
    } cbs_req_t;

    typedef enum logic [1:0] {
        CBS_ST_IDLE = 2'b01,
        CBS_ST_SECOND = 2'b10
    } cbs_state_t;
endpackage

// [hdl/cbs_unit.sv]
`timescale 1ns/1ps
module cbs_unit (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire cbs_pkg::cbs_req_t req,
    input wire logic [7:0] status_flags_register,
    output logic ready,
    output logic [cbs_pkg::PC_W-1:0] pc,
    output logic taken,
    output logic done,
    output logic [7:0] flags_out
);
    // ****************************************
    // condition evaluation
    // ****************************************
    logic cond;
    logic [cbs_pkg::PC_W-1:0] target;
    logic [cbs_pkg::PC_W-1:0] skip_pc;
    logic [cbs_pkg::PC_W-1:0] k_ext;
    cbs_pkg::cbs_state_t state_reg;
    logic accept;

    assign accept = req_valid && (state_reg == cbs_pkg::CBS_ST_IDLE);
    // sign extension keeps backward targets reachable
    assign k_ext = {{(cbs_pkg::PC_W-cbs_pkg::K_W){req.offset[cbs_pkg::K_W-1]}}, req.offset};
    assign target = pc + cbs_pkg::PC_ONE + k_ext;
    assign skip_pc = pc + (req.next_is_long ? cbs_pkg::PC_THREE : cbs_pkg::PC_TWO);

    always_comb begin
        case (req.op)
            cbs_pkg::CBS_OP_SKIP_BIT_SET: cond = req.io_value[req.sel];
            cbs_pkg::CBS_OP_BRANCH_FLAG_SET: cond = status_flags_register[req.sel];
            cbs_pkg::CBS_OP_BRANCH_FLAG_CLEAR: cond = !status_flags_register[req.sel];
            cbs_pkg::CBS_OP_BRANCH_ZERO_SET:
                cond = status_flags_register[cbs_pkg::FLAG_ZERO];
            cbs_pkg::CBS_OP_BRANCH_ZERO_CLEAR:
                cond = !status_flags_register[cbs_pkg::FLAG_ZERO];
            cbs_pkg::CBS_OP_BRANCH_CARRY_SET:
                cond = status_flags_register[cbs_pkg::FLAG_CARRY];
            cbs_pkg::CBS_OP_BRANCH_CARRY_CLEAR, cbs_pkg::CBS_OP_BRANCH_UNSIGNED_GE:
                cond = !status_flags_register[cbs_pkg::FLAG_CARRY];
            default: cond = 1'b0;
        endcase
    end

    // ****************************************
    // sequencing: taken path spends a second cycle
    // ****************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= cbs_pkg::CBS_ST_IDLE;
            ready <= 1'b0;
        end else begin
            case (state_reg)
                cbs_pkg::CBS_ST_IDLE: begin
                    ready <= 1'b1;
                    if (accept && cond && req.op != cbs_pkg::CBS_OP_NONE) begin
                        state_reg <= cbs_pkg::CBS_ST_SECOND;
                        ready <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= cbs_pkg::CBS_ST_IDLE;
                    ready <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pc <= cbs_pkg::PC_RESET;
            taken <= 1'b0;
            done <= 1'b0;
        end else begin
            taken <= 1'b0;
            done <= 1'b0;
            if (state_reg == cbs_pkg::CBS_ST_SECOND) begin
                done <= 1'b1;
                taken <= 1'b1;
            end else if (accept && req.op != cbs_pkg::CBS_OP_NONE) begin
                if (!cond) begin
                    pc <= pc + cbs_pkg::PC_ONE;
                    done <= 1'b1;
                end else if (req.op == cbs_pkg::CBS_OP_SKIP_BIT_SET) begin
                    pc <= skip_pc;
                end else begin
                    pc <= target;
                end
            end
        end
    end

    // flags pass through untouched
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            flags_out <= 8'h00;
        end else begin
            flags_out <= status_flags_register;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_FLAGS_KEPT: assert property (@(posedge clock) disable iff (sys_rst)
        1'b1 |=> flags_out == $past(status_flags_register))
        else $error("flags changed");
    AST_NOT_TAKEN_ONE: assert property (@(posedge clock) disable iff (sys_rst)
        accept && req.op != cbs_pkg::CBS_OP_NONE && !cond |=> done && !taken && ready)
        else $error("not-taken not one cycle");
    AST_TAKEN_TWO: assert property (@(posedge clock) disable iff (sys_rst)
        accept && req.op != cbs_pkg::CBS_OP_NONE && cond |=> !done ##1 done && taken)
        else $error("taken not two cycles");
    AST_BRANCH_TARGET: assert property (@(posedge clock) disable iff (sys_rst)
        accept && cond && req.op != cbs_pkg::CBS_OP_NONE
        && req.op != cbs_pkg::CBS_OP_SKIP_BIT_SET |=> pc == $past(target))
        else $error("bad branch target");
    AST_SKIP_TARGET: assert property (@(posedge clock) disable iff (sys_rst)
        accept && cond && req.op == cbs_pkg::CBS_OP_SKIP_BIT_SET
        |=> pc == $past(pc) + (($past(req.next_is_long)) ? cbs_pkg::PC_THREE : cbs_pkg::PC_TWO))
        else $error("bad skip target");
    AST_ZERO_SET: assert property (@(posedge clock) disable iff (sys_rst)
        accept && req.op == cbs_pkg::CBS_OP_BRANCH_ZERO_SET
        |-> cond == status_flags_register[cbs_pkg::FLAG_ZERO])
        else $error("zero-set test wrong");
    AST_ZERO_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
        accept && req.op == cbs_pkg::CBS_OP_BRANCH_ZERO_CLEAR
        |-> cond != status_flags_register[cbs_pkg::FLAG_ZERO])
        else $error("zero-clear test wrong");
    AST_CARRY_SET: assert property (@(posedge clock) disable iff (sys_rst)
        accept && req.op == cbs_pkg::CBS_OP_BRANCH_CARRY_SET
        |-> cond == status_flags_register[cbs_pkg::FLAG_CARRY])
        else $error("carry-set test wrong");
    AST_CARRY_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
        accept && (req.op == cbs_pkg::CBS_OP_BRANCH_CARRY_CLEAR
        || req.op == cbs_pkg::CBS_OP_BRANCH_UNSIGNED_GE)
        |-> cond != status_flags_register[cbs_pkg::FLAG_CARRY])
        else $error("carry-clear test wrong");
    AST_FLAG_SEL: assert property (@(posedge clock) disable iff (sys_rst)
        accept && (req.op == cbs_pkg::CBS_OP_BRANCH_FLAG_SET
        || req.op == cbs_pkg::CBS_OP_BRANCH_FLAG_CLEAR)
        |-> cond == (status_flags_register[req.sel]
        ^ (req.op == cbs_pkg::CBS_OP_BRANCH_FLAG_CLEAR)))
        else $error("flag select test wrong");

    // ****************************************
    // sequencing checks
    // ****************************************
    // ready lags reset by one edge, so the first cycle after release is left out
    AST_READY_STATE: assert property (@(posedge clock) disable iff (sys_rst)
        !$past(sys_rst) |-> ready == (state_reg == cbs_pkg::CBS_ST_IDLE))
        else $error("ready does not follow state");

    AST_SECOND_LEAVES: assert property (@(posedge clock) disable iff (sys_rst)
        state_reg == cbs_pkg::CBS_ST_SECOND |=> state_reg == cbs_pkg::CBS_ST_IDLE)
        else $error("second cycle not left");

    AST_STATE_ONEHOT: assert property (@(posedge clock) disable iff (sys_rst)
        $onehot(state_reg))
        else $error("state not one-hot");

    // requests during the second cycle must leave no trace on the pc
    AST_PC_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
        !(accept && req.op != cbs_pkg::CBS_OP_NONE) |=> $stable(pc))
        else $error("pc moved without a request");

    AST_REFUSED_NO_PC: assert property (@(posedge clock) disable iff (sys_rst)
        state_reg == cbs_pkg::CBS_ST_SECOND |=> $stable(pc) && taken)
        else $error("request taken in second cycle");

    AST_NOT_TAKEN_PC: assert property (@(posedge clock) disable iff (sys_rst)
        accept && req.op != cbs_pkg::CBS_OP_NONE && !cond
        |=> pc == $past(pc) + cbs_pkg::PC_ONE)
        else $error("not-taken pc wrong");

    AST_NONE_IGNORED: assert property (@(posedge clock) disable iff (sys_rst)
        accept && req.op == cbs_pkg::CBS_OP_NONE |=> !done && !taken && ready)
        else $error("empty op had an effect");

    AST_TAKEN_WITH_DONE: assert property (@(posedge clock) disable iff (sys_rst)
        taken |-> done)
        else $error("taken without done");

    AST_TAKEN_PULSE: assert property (@(posedge clock) disable iff (sys_rst)
        taken |=> !taken)
        else $error("taken longer than one cycle");

    AST_DONE_CAUSE: assert property (@(posedge clock) disable iff (sys_rst)
        done |-> $past(state_reg == cbs_pkg::CBS_ST_SECOND)
        || $past(accept && req.op != cbs_pkg::CBS_OP_NONE && !cond))
        else $error("done without a finished instruction");

    // no disable here: the reset values themselves are the point
    AST_RESET_VALUES: assert property (@(posedge clock)
        sys_rst |=> pc == cbs_pkg::PC_RESET && !ready && !taken && !done
        && flags_out == 8'h00)
        else $error("reset values wrong");

    AST_SKIP_TEST: assert property (@(posedge clock) disable iff (sys_rst)
        accept && req.op == cbs_pkg::CBS_OP_SKIP_BIT_SET
        |-> cond == req.io_value[req.sel])
        else $error("skip bit test wrong");

    // a taken skip spends two cycles, just like a taken branch
    AST_SKIP_TWO: assert property (@(posedge clock) disable iff (sys_rst)
        accept && req.op == cbs_pkg::CBS_OP_SKIP_BIT_SET && cond
        |=> !ready ##1 taken && done)
        else $error("taken skip not two cycles");
endmodule

// [bench/cbs_unit_tb.sv]
`timescale 1ns/1ps
module cbs_unit_tb;
    // ****************************************
    // stimulus and design
    // ****************************************
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    cbs_pkg::cbs_req_t req = '0;
    cbs_pkg::cbs_req_t r;
    logic [7:0] status_flags_register = 8'h00;
    logic ready;
    logic taken;
    logic done;
    logic [cbs_pkg::PC_W-1:0] pc;
    logic [7:0] flags_out;
    logic [cbs_pkg::PC_W-1:0] exp_pc = 16'h0000;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;

    cbs_unit i_dut (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
        .status_flags_register(status_flags_register), .ready(ready), .pc(pc),
        .taken(taken), .done(done), .flags_out(flags_out));

    initial begin
        forever #4 clock = ~clock;
    end

    // a hang counts as a mismatch
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            conclude();
        end
    end

    // ****************************************
    // checking
    // ****************************************
    task automatic conclude();
        if (n_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, e, g);
        end
    endtask

    function automatic logic hit(cbs_pkg::cbs_req_t q, logic [7:0] f);
        case (q.op)
            cbs_pkg::CBS_OP_SKIP_BIT_SET: hit = q.io_value[q.sel]; // io bit
            cbs_pkg::CBS_OP_BRANCH_FLAG_SET: hit = f[q.sel]; // flag set
            cbs_pkg::CBS_OP_BRANCH_FLAG_CLEAR: hit = !f[q.sel]; // flag clear
            cbs_pkg::CBS_OP_BRANCH_ZERO_SET: hit = f[1]; // zero
            cbs_pkg::CBS_OP_BRANCH_ZERO_CLEAR: hit = !f[1]; // not zero
            cbs_pkg::CBS_OP_BRANCH_CARRY_SET: hit = f[0]; // carry
            cbs_pkg::CBS_OP_BRANCH_CARRY_CLEAR: hit = !f[0]; // no carry
            cbs_pkg::CBS_OP_BRANCH_UNSIGNED_GE: hit = !f[0]; // no carry
            default: hit = 1'b0;
        endcase
    endfunction

    // entered just after an edge with ready high; checked just after the accepting edge
    // valid stays up after a not-taken request, but drops after a taken one, so the call after a taken request pulses it
    task automatic run(input cbs_pkg::cbs_req_t q, input logic [7:0] f);
        logic h;
        logic act;
        h = hit(q, f);
        act = q.op != cbs_pkg::CBS_OP_NONE;
        status_flags_register = f;
        req = q;
        req_valid = 1'b1;
        @(posedge clock);
        #1;
        if (h) req_valid = 1'b0;
        if (!h && act) begin
            exp_pc = exp_pc + cbs_pkg::PC_ONE;
        end else if (h && q.op == cbs_pkg::CBS_OP_SKIP_BIT_SET) begin
            exp_pc = exp_pc + (q.next_is_long ? cbs_pkg::PC_THREE : cbs_pkg::PC_TWO);
        end else if (h) begin
            exp_pc = exp_pc + cbs_pkg::PC_ONE + {{9{q.offset[6]}}, q.offset};
        end
        chk("pc", exp_pc, pc);
        chk("done", !h && act, done);
        chk("ready", !h, ready);
        chk("flags_out", f, flags_out);
        if (h) begin
            @(posedge clock);
            #1;
            chk("taken", 1'b1, taken);
            chk("done", 1'b1, done);
        end else chk("taken", 1'b0, taken);
    endtask

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        void'($urandom(32'h74B7B0F8));
        repeat (16) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        @(posedge clock);
        #1;
        run('{cbs_pkg::CBS_OP_NONE, 3'h0, 7'h05, 8'h00, 1'b0}, 8'h00); // ignored op
        run('{cbs_pkg::CBS_OP_BRANCH_ZERO_SET, 3'h0, 7'h40, 8'h00, 1'b0}, 8'h02);
        run('{cbs_pkg::CBS_OP_BRANCH_CARRY_CLEAR, 3'h0, 7'h3F, 8'h00, 1'b0}, 8'hFE);
        run('{cbs_pkg::CBS_OP_SKIP_BIT_SET, 3'h7, 7'h00, 8'h80, 1'b1}, 8'h00);
        run('{cbs_pkg::CBS_OP_SKIP_BIT_SET, 3'h7, 7'h00, 8'h7F, 1'b1}, 8'hFF);
        for (int i = 0; i < 600; i++) begin
            r = $bits(r)'($urandom);
            r.op = cbs_pkg::cbs_op_t'(4'h1 + 4'($urandom_range(7)));
            run(r, 8'($urandom));
        end
        conclude();
    end
endmodule
